// file: inc/ccas_pkg.sv
// Constants for the clear-channel alarm control and status block
package ccas_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int CCAS_NPORT = 4;
	localparam int CCAS_AW = 12;
	localparam int CCAS_DW = 16;
	localparam int CCAS_OFS_W = 8;
	localparam int CCAS_PORT_W = 2;

	// ----------------------------------------------------------------
	// Port space decode: port p sits at byte address (2p+1) * 0x100
	// ----------------------------------------------------------------
	localparam int CCAS_PORT_LSB = 9;
	localparam int CCAS_PORT_ODD_BIT = 8;

	// ----------------------------------------------------------------
	// Register offsets within one port space
	// ----------------------------------------------------------------
	localparam logic [7:0] CCAS_OFS_TX_CTRL = 8'h18;
	localparam logic [7:0] CCAS_OFS_RX_CTRL = 8'h20;
	localparam logic [7:0] CCAS_OFS_RX_LIVE = 8'h24;
	localparam logic [7:0] CCAS_OFS_RX_LATCH = 8'h28;
	localparam logic [7:0] CCAS_OFS_RX_IE = 8'h2C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CCAS_BIT_TX_FORCE = 0;
	localparam int CCAS_BIT_MAN_INSERT = 12;
	localparam int CCAS_BIT_AUTO_DISABLE = 11;
	localparam int CCAS_BIT_ALL_ONES = 8;
	localparam int CCAS_BIT_SIG_ABSENT = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic CCAS_RST_BIT = 1'b0;
	localparam logic [15:0] CCAS_RST_WORD = 16'h0000;

endpackage : ccas_pkg

// file: logic/ccas_sync.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none

module ccas_sync
	import ccas_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_i,
	output logic sync_o
);

	logic meta_q;
	logic sync_q;

	// ----------------------------------------------------------------
	// Two flops, first read only by second
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= CCAS_RST_BIT;
			sync_q <= CCAS_RST_BIT;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule : ccas_sync

`default_nettype wire

// file: logic/ccas_change_latch.sv
// Live status flop with sticky change latch, write-one-to-clear
`timescale 1ns/100ps
`default_nettype none

module ccas_change_latch
	import ccas_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic level_i,
	input wire logic clear_i,
	output logic live_o,
	output logic latch_o
);

	logic live_q;
	logic latch_q;
	logic change;

	// ----------------------------------------------------------------
	// Live level and change detect
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			live_q <= CCAS_RST_BIT;
		end else begin
			live_q <= level_i;
		end
	end

	assign change = live_q ^ level_i;

	// ----------------------------------------------------------------
	// Sticky latch, set wins over clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			latch_q <= CCAS_RST_BIT;
		end else if (change) begin
			latch_q <= 1'b1;
		end else if (clear_i) begin
			latch_q <= 1'b0;
		end
	end

	assign live_o = live_q;
	assign latch_o = latch_q;

endmodule : ccas_change_latch

`default_nettype wire

// file: logic/ccas_top.sv
// Clear-channel alarm control, live status, change latches and interrupt
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Transmit force bit set replaces outgoing data with ones; clear passes data.
// - Transmit forcing is software bit OR the external force pin.
// - Manual insertion bit set forces downstream receive data to ones.
// - Signal absence inserts downstream ones unless auto-disable bit is set.
// - Live bit 8 reads one while unframed all-ones condition holds.
// - Live bit 0 follows the external signal-absent pin level.
// - All-ones change latch sets on any edge of live all-ones bit.
// - Signal-absent change latch sets on any edge of live bit.
// - All-ones latch with its enable set raises the interrupt.
// - Signal-absent latch with its enable set raises the interrupt.
module ccas_top
	import ccas_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [CCAS_AW-1:0] ADDR,
	input wire logic [CCAS_DW-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [CCAS_DW-1:0] RDATA,
	input wire logic [CCAS_NPORT-1:0] TX_DATA_IN,
	input wire logic [CCAS_NPORT-1:0] TRANSMIT_ALARM_FORCE,
	output logic [CCAS_NPORT-1:0] TX_DATA_OUT,
	input wire logic [CCAS_NPORT-1:0] RX_DATA_IN,
	input wire logic [CCAS_NPORT-1:0] UNFRAMED_ALL_ONES_IN,
	input wire logic [CCAS_NPORT-1:0] SIGNAL_ABSENT_INPUT,
	output logic [CCAS_NPORT-1:0] RX_DATA_OUT,
	output logic IRQ
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic port_hit;
	logic [CCAS_PORT_W-1:0] port_idx;
	logic [CCAS_OFS_W-1:0] ofs;
	logic wr_tx_ctrl;
	logic wr_rx_ctrl;
	logic wr_rx_latch;
	logic wr_rx_ie;

	assign port_hit = ADDR[CCAS_PORT_ODD_BIT];
	assign port_idx = ADDR[CCAS_PORT_LSB +: CCAS_PORT_W];
	assign ofs = ADDR[CCAS_OFS_W-1:0];

	always_comb begin
		wr_tx_ctrl = 1'b0;
		wr_rx_ctrl = 1'b0;
		wr_rx_latch = 1'b0;
		wr_rx_ie = 1'b0;
		if (!(WR && port_hit)) begin
			wr_tx_ctrl = 1'b0;
		end else if (ofs == CCAS_OFS_TX_CTRL) begin
			wr_tx_ctrl = 1'b1;
		end else if (ofs == CCAS_OFS_RX_CTRL) begin
			wr_rx_ctrl = 1'b1;
		end else if (ofs == CCAS_OFS_RX_LATCH) begin
			wr_rx_latch = 1'b1;
		end else if (ofs == CCAS_OFS_RX_IE) begin
			wr_rx_ie = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Read strobe decode
	// ----------------------------------------------------------------
	logic rd_tx_ctrl;
	logic rd_rx_ctrl;
	logic rd_rx_live;
	logic rd_rx_latch;
	logic rd_rx_ie;

	always_comb begin
		rd_tx_ctrl = 1'b0;
		rd_rx_ctrl = 1'b0;
		rd_rx_live = 1'b0;
		rd_rx_latch = 1'b0;
		rd_rx_ie = 1'b0;
		if (!(RD && port_hit)) begin
			rd_tx_ctrl = 1'b0;
		end else if (ofs == CCAS_OFS_TX_CTRL) begin
			rd_tx_ctrl = 1'b1;
		end else if (ofs == CCAS_OFS_RX_CTRL) begin
			rd_rx_ctrl = 1'b1;
		end else if (ofs == CCAS_OFS_RX_LIVE) begin
			rd_rx_live = 1'b1;
		end else if (ofs == CCAS_OFS_RX_LATCH) begin
			rd_rx_latch = 1'b1;
		end else if (ofs == CCAS_OFS_RX_IE) begin
			rd_rx_ie = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Per-port state
	// ----------------------------------------------------------------
	logic tx_force_q [CCAS_NPORT];
	logic man_insert_q [CCAS_NPORT];
	logic auto_disable_q [CCAS_NPORT];
	logic ones_ie_q [CCAS_NPORT];
	logic absent_ie_q [CCAS_NPORT];
	logic tx_out_q [CCAS_NPORT];
	logic rx_out_q [CCAS_NPORT];
	logic force_pin [CCAS_NPORT];
	logic absent_pin [CCAS_NPORT];
	logic ones_live [CCAS_NPORT];
	logic absent_live [CCAS_NPORT];
	logic ones_latch [CCAS_NPORT];
	logic absent_latch [CCAS_NPORT];
	logic [CCAS_DW-1:0] word_tx_ctrl [CCAS_NPORT];
	logic [CCAS_DW-1:0] word_rx_ctrl [CCAS_NPORT];
	logic [CCAS_DW-1:0] word_rx_live [CCAS_NPORT];
	logic [CCAS_DW-1:0] word_rx_latch [CCAS_NPORT];
	logic [CCAS_DW-1:0] word_rx_ie [CCAS_NPORT];
	logic [CCAS_NPORT-1:0] irq_term;

	genvar p;
	generate
		for (p = 0; p < CCAS_NPORT; p++) begin : g_port
			logic sel;
			logic wr_tx_port;
			logic wr_rx_port;
			logic wr_latch_port;
			logic wr_ie_port;
			logic clr_ones;
			logic clr_absent;
			logic tx_force_any;
			logic auto_insert;
			logic ones_req;
			logic absent_req;

			assign sel = (port_idx == CCAS_PORT_W'(p));
			assign wr_tx_port = wr_tx_ctrl && sel;
			assign wr_rx_port = wr_rx_ctrl && sel;
			assign wr_latch_port = wr_rx_latch && sel;
			assign wr_ie_port = wr_rx_ie && sel;
			// One-write clear of this port's latches
			assign clr_ones = wr_latch_port && WDATA[CCAS_BIT_ALL_ONES];
			assign clr_absent = wr_latch_port && WDATA[CCAS_BIT_SIG_ABSENT];

			// --------------------------------------------------------
			// Pin synchronisers
			// --------------------------------------------------------
			ccas_sync u_force_sync (
				.clk(CLK_SYS),
				.rst_n(RST_N),
				.async_i(TRANSMIT_ALARM_FORCE[p]),
				.sync_o(force_pin[p])
			);

			ccas_sync u_absent_sync (
				.clk(CLK_SYS),
				.rst_n(RST_N),
				.async_i(SIGNAL_ABSENT_INPUT[p]),
				.sync_o(absent_pin[p])
			);

			// --------------------------------------------------------
			// Control registers, one copy per port
			// --------------------------------------------------------
			always_ff @(posedge CLK_SYS) begin
				if (!RST_N) begin
					tx_force_q[p] <= CCAS_RST_BIT;
				end else if (wr_tx_port) begin
					tx_force_q[p] <= WDATA[CCAS_BIT_TX_FORCE];
				end
			end

			always_ff @(posedge CLK_SYS) begin
				if (!RST_N) begin
					man_insert_q[p] <= CCAS_RST_BIT;
				end else if (wr_rx_port) begin
					man_insert_q[p] <= WDATA[CCAS_BIT_MAN_INSERT];
				end
			end

			always_ff @(posedge CLK_SYS) begin
				if (!RST_N) begin
					auto_disable_q[p] <= CCAS_RST_BIT;
				end else if (wr_rx_port) begin
					auto_disable_q[p] <= WDATA[CCAS_BIT_AUTO_DISABLE];
				end
			end

			always_ff @(posedge CLK_SYS) begin
				if (!RST_N) begin
					ones_ie_q[p] <= CCAS_RST_BIT;
				end else if (wr_ie_port) begin
					ones_ie_q[p] <= WDATA[CCAS_BIT_ALL_ONES];
				end
			end

			always_ff @(posedge CLK_SYS) begin
				if (!RST_N) begin
					absent_ie_q[p] <= CCAS_RST_BIT;
				end else if (wr_ie_port) begin
					absent_ie_q[p] <= WDATA[CCAS_BIT_SIG_ABSENT];
				end
			end

			// --------------------------------------------------------
			// Live status and change latches
			// --------------------------------------------------------
			ccas_change_latch u_ones_latch (
				.clk(CLK_SYS),
				.rst_n(RST_N),
				.level_i(UNFRAMED_ALL_ONES_IN[p]),
				.clear_i(clr_ones),
				.live_o(ones_live[p]),
				.latch_o(ones_latch[p])
			);

			ccas_change_latch u_absent_latch (
				.clk(CLK_SYS),
				.rst_n(RST_N),
				.level_i(absent_pin[p]),
				.clear_i(clr_absent),
				.live_o(absent_live[p]),
				.latch_o(absent_latch[p])
			);

			// --------------------------------------------------------
			// Transmit forcing
			// --------------------------------------------------------
			assign tx_force_any = tx_force_q[p] || force_pin[p];

			always_ff @(posedge CLK_SYS) begin
				if (!RST_N) begin
					tx_out_q[p] <= CCAS_RST_BIT;
				end else if (tx_force_any) begin
					tx_out_q[p] <= 1'b1;
				end else begin
					tx_out_q[p] <= TX_DATA_IN[p];
				end
			end

			// --------------------------------------------------------
			// Downstream alarm insertion
			// --------------------------------------------------------
			assign auto_insert = absent_live[p] && !auto_disable_q[p];

			always_ff @(posedge CLK_SYS) begin
				if (!RST_N) begin
					rx_out_q[p] <= CCAS_RST_BIT;
				end else if (man_insert_q[p]) begin
					rx_out_q[p] <= 1'b1;
				end else if (auto_insert) begin
					rx_out_q[p] <= 1'b1;
				end else begin
					rx_out_q[p] <= RX_DATA_IN[p];
				end
			end

			// --------------------------------------------------------
			// Interrupt terms
			// --------------------------------------------------------
			assign ones_req = ones_latch[p] && ones_ie_q[p];
			assign absent_req = absent_latch[p] && absent_ie_q[p];
			assign irq_term[p] = ones_req || absent_req;

			// --------------------------------------------------------
			// Read words of this port
			// --------------------------------------------------------
			always_comb begin
				word_tx_ctrl[p] = CCAS_RST_WORD;
				word_tx_ctrl[p][CCAS_BIT_TX_FORCE] = tx_force_q[p];
			end

			always_comb begin
				word_rx_ctrl[p] = CCAS_RST_WORD;
				word_rx_ctrl[p][CCAS_BIT_MAN_INSERT] = man_insert_q[p];
				word_rx_ctrl[p][CCAS_BIT_AUTO_DISABLE] = auto_disable_q[p];
			end

			always_comb begin
				word_rx_live[p] = CCAS_RST_WORD;
				word_rx_live[p][CCAS_BIT_ALL_ONES] = ones_live[p];
				word_rx_live[p][CCAS_BIT_SIG_ABSENT] = absent_live[p];
			end

			always_comb begin
				word_rx_latch[p] = CCAS_RST_WORD;
				word_rx_latch[p][CCAS_BIT_ALL_ONES] = ones_latch[p];
				word_rx_latch[p][CCAS_BIT_SIG_ABSENT] = absent_latch[p];
			end

			always_comb begin
				word_rx_ie[p] = CCAS_RST_WORD;
				word_rx_ie[p][CCAS_BIT_ALL_ONES] = ones_ie_q[p];
				word_rx_ie[p][CCAS_BIT_SIG_ABSENT] = absent_ie_q[p];
			end

			assign TX_DATA_OUT[p] = tx_out_q[p];
			assign RX_DATA_OUT[p] = rx_out_q[p];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read data, valid only in the cycle after the strobe
	// ----------------------------------------------------------------
	logic [CCAS_DW-1:0] rdata_d;
	logic [CCAS_DW-1:0] rdata_q;

	always_comb begin
		rdata_d = CCAS_RST_WORD;
		if (rd_tx_ctrl) begin
			rdata_d = word_tx_ctrl[port_idx];
		end else if (rd_rx_ctrl) begin
			rdata_d = word_rx_ctrl[port_idx];
		end else if (rd_rx_live) begin
			rdata_d = word_rx_live[port_idx];
		end else if (rd_rx_latch) begin
			rdata_d = word_rx_latch[port_idx];
		end else if (rd_rx_ie) begin
			rdata_d = word_rx_ie[port_idx];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			rdata_q <= CCAS_RST_WORD;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign RDATA = rdata_q;

	// ----------------------------------------------------------------
	// Level interrupt
	// ----------------------------------------------------------------
	logic irq_q;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			irq_q <= CCAS_RST_BIT;
		end else begin
			irq_q <= |irq_term;
		end
	end

	assign IRQ = irq_q;

endmodule : ccas_top

`default_nettype wire

// file: dv/ccas_liu_model.sv
// Line interface model driving the signal-absent pins
`timescale 1ns/100ps
`default_nettype none

module ccas_liu_model
	import ccas_pkg::*;
(
	input wire logic clk,
	input wire logic slow,
	input wire logic [CCAS_NPORT-1:0] loss_req,
	output logic [CCAS_NPORT-1:0] loss_pin
);
	// Prompt answer after one clock, slow answer after three
	logic [CCAS_NPORT-1:0] d1_q = 4'h0;
	logic [CCAS_NPORT-1:0] d2_q = 4'h0;
	logic [CCAS_NPORT-1:0] d3_q = 4'h0;
	always @(posedge clk) begin
		d1_q <= loss_req;
		d2_q <= d1_q;
		d3_q <= d2_q;
	end
	assign loss_pin = slow ? d3_q : d1_q;
endmodule : ccas_liu_model

`default_nettype wire

// file: dv/ccas_top_assertions.sv
// Port checker for the clear-channel alarm block
`timescale 1ns/100ps
`default_nettype none

module ccas_top_assertions
	import ccas_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [CCAS_AW-1:0] ADDR,
	input wire logic [CCAS_DW-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [CCAS_DW-1:0] RDATA,
	input wire logic [CCAS_NPORT-1:0] TX_DATA_IN,
	input wire logic [CCAS_NPORT-1:0] TRANSMIT_ALARM_FORCE,
	input wire logic [CCAS_NPORT-1:0] TX_DATA_OUT,
	input wire logic [CCAS_NPORT-1:0] RX_DATA_IN,
	input wire logic [CCAS_NPORT-1:0] UNFRAMED_ALL_ONES_IN,
	input wire logic [CCAS_NPORT-1:0] SIGNAL_ABSENT_INPUT,
	input wire logic [CCAS_NPORT-1:0] RX_DATA_OUT,
	input wire logic IRQ
);
	// ----------------------------------------------------------------
	// Reference state
	// ----------------------------------------------------------------
	logic [1:0] up_q;
	logic [3:0] tf_q, man_q, dis_q, ie8_q, ie0_q, ua_q, s1_q, s2_q, s3_q, t1_q, t2_q, l8_q, l0_q;
	wire logic [1:0] p = ADDR[10:9];
	wire logic [7:0] ofs = ADDR[7:0];
	wire logic wp = WR && ADDR[8];
	wire logic [3:0] sel = 4'h1 << p;
	wire logic [3:0] clr = (wp && ofs == CCAS_OFS_RX_LATCH) ? sel : 4'h0;
	wire logic [3:0] tx_x = TX_DATA_IN | tf_q | t2_q;
	wire logic [3:0] rx_x = RX_DATA_IN | man_q | (s3_q & ~dis_q);
	wire logic irq_x = |((l8_q & ie8_q) | (l0_q & ie0_q));
	wire logic rd_lv = RD && ADDR[8] && ofs == CCAS_OFS_RX_LIVE;
	wire logic rd_lt = RD && ADDR[8] && ofs == CCAS_OFS_RX_LATCH;
	wire logic rd_out = RD && !ADDR[8];
	wire logic [15:0] lv_w = {7'h00, ua_q[p], 7'h00, s3_q[p]};
	wire logic [15:0] lt_w = {7'h00, l8_q[p], 7'h00, l0_q[p]};
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			{tf_q, man_q, dis_q, ie8_q, ie0_q} <= 20'h00000;
		end else if (wp) begin
			if (ofs == CCAS_OFS_TX_CTRL) tf_q[p] <= WDATA[0];
			if (ofs == CCAS_OFS_RX_CTRL) man_q[p] <= WDATA[12];
			if (ofs == CCAS_OFS_RX_CTRL) dis_q[p] <= WDATA[11];
			if (ofs == CCAS_OFS_RX_IE) ie8_q[p] <= WDATA[8];
			if (ofs == CCAS_OFS_RX_IE) ie0_q[p] <= WDATA[0];
		end
	end
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			{ua_q, s1_q, s2_q, s3_q, t1_q, t2_q, l8_q, l0_q} <= 32'h00000000;
			up_q <= 2'h0;
		end else begin
			{s3_q, s2_q, s1_q} <= {s2_q, s1_q, SIGNAL_ABSENT_INPUT};
			{t2_q, t1_q} <= {t1_q, TRANSMIT_ALARM_FORCE};
			ua_q <= UNFRAMED_ALL_ONES_IN;
			l8_q <= (l8_q & ~(clr & {4{WDATA[8]}})) | (UNFRAMED_ALL_ONES_IN ^ ua_q);
			l0_q <= (l0_q & ~(clr & {4{WDATA[0]}})) | (s2_q ^ s3_q);
			if (up_q != 2'h3) up_q <= up_q + 2'h1;
		end
	end
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	chk_tx_force_or: assert property (up_q[1] |-> TX_DATA_OUT == $past(tx_x))
		else $error("transmit data or forcing wrong");
	chk_rx_insert: assert property (up_q[1] |-> RX_DATA_OUT == $past(rx_x))
		else $error("downstream insertion wrong");
	chk_live_read: assert property ($past(rd_lv) |-> RDATA == $past(lv_w))
		else $error("live status read wrong");
	chk_latch_read: assert property ($past(rd_lt) |-> RDATA == $past(lt_w))
		else $error("change latch read wrong");
	chk_irq_level: assert property (up_q[1] |-> IRQ == $past(irq_x))
		else $error("interrupt level wrong");
	chk_irq_rise: assert property ($rose(irq_x) |=> IRQ)
		else $error("interrupt not raised");
	chk_irq_clear: assert property ($fell(irq_x) |=> !IRQ)
		else $error("interrupt not dropped");
	chk_outside_read: assert property ($past(rd_out) |-> RDATA == 16'h0000)
		else $error("read outside port space not zero");
endmodule : ccas_top_assertions

bind ccas_top ccas_top_assertions ccas_top_assertions_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TX_DATA_IN(TX_DATA_IN),
	.TRANSMIT_ALARM_FORCE(TRANSMIT_ALARM_FORCE), .TX_DATA_OUT(TX_DATA_OUT), .IRQ(IRQ),
	.RX_DATA_IN(RX_DATA_IN), .UNFRAMED_ALL_ONES_IN(UNFRAMED_ALL_ONES_IN),
	.SIGNAL_ABSENT_INPUT(SIGNAL_ABSENT_INPUT), .RX_DATA_OUT(RX_DATA_OUT));

`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the clear-channel alarm block
`timescale 1ns/100ps
`default_nettype none

module tb
	import ccas_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic slow = 1'b0;
	logic irq;
	logic [11:0] addr = 12'h000;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [3:0] txi = 4'h0, taf = 4'h0, rxi = 4'h0, ua = 4'h0, lreq = 4'h0;
	logic [3:0] txo, rxo, signal_absent_state, tf, rf;
	logic [15:0] wv [4][5];
	logic [7:0] ofs [5] = '{CCAS_OFS_TX_CTRL, CCAS_OFS_RX_CTRL, CCAS_OFS_RX_LIVE,
		CCAS_OFS_RX_LATCH, CCAS_OFS_RX_IE};
	logic [15:0] msk [5] = '{16'h0001, 16'h1800, 16'h0000, 16'h0000, 16'h0101};
	int error_cnt = 0;
	int samples_checked = 0;
	always #20 clk = ~clk;
	ccas_top ccas_top_inst (.CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .TX_DATA_IN(txi), .TRANSMIT_ALARM_FORCE(taf), .TX_DATA_OUT(txo),
		.RX_DATA_IN(rxi), .UNFRAMED_ALL_ONES_IN(ua), .SIGNAL_ABSENT_INPUT(signal_absent_state),
		.RX_DATA_OUT(rxo), .IRQ(irq));
	ccas_liu_model ccas_liu_model_inst (.clk(clk), .slow(slow), .loss_req(lreq), .loss_pin(signal_absent_state));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [11:0] ra(input int p, input logic [7:0] o);
		return 12'((2 * p + 1) * 256) | {4'h0, o};
	endfunction : ra
	function automatic logic [3:0] fx(input logic [3:0] d, input logic [3:0] f);
		return d | f;
	endfunction : fx
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	task automatic wr16(input logic [11:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr16
	task automatic rchk(input logic [11:0] a, input logic [15:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		cmp(rdata, e);
		@(posedge clk);
	endtask : rchk
	task automatic ichk(input logic e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		cmp(16'(irq), 16'(e));
		@(posedge clk);
	endtask : ichk
	task automatic flow(input logic [3:0] tx_f, input logic [3:0] rx_f);
		repeat (6) begin
			txi <= 4'($urandom);
			rxi <= 4'($urandom);
			@(posedge clk);
			@(negedge clk);
			cmp(16'(txo), 16'(fx(txi, tx_f)));
			cmp(16'(rxo), 16'(fx(rxi, rx_f)));
			@(posedge clk);
		end
	endtask : flow
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	initial begin
		#(40 * 20000);
		error_cnt++;
		results();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(48912));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int p = 0; p < 4; p++) begin
			for (int i = 0; i < 5; i++) begin
				rchk(ra(p, ofs[i]), 16'h0000);
				wv[p][i] = 16'($urandom);
				wr16(ra(p, ofs[i]), wv[p][i]);
			end
			tf[p] = wv[p][0][0];
			rf[p] = wv[p][1][12];
		end
		for (int p = 0; p < 4; p++)
			for (int i = 0; i < 5; i++) rchk(ra(p, ofs[i]), wv[p][i] & msk[i]);
		wr16(ra(0, 8'h22), 16'hFFFF);
		rchk(ra(0, 8'h22), 16'h0000);
		rchk(12'h018, 16'h0000);
		$display("test registers done");
		flow(tf, rf);
		lreq <= 4'hF;
		repeat (6) @(posedge clk);
		for (int m = 0; m < 4; m++) begin
			for (int p = 0; p < 4; p++) wr16(ra(p, CCAS_OFS_RX_CTRL), 16'(m) << 11);
			flow(tf, (m[1] || !m[0]) ? 4'hF : 4'h0);
		end
		for (int m = 0; m < 4; m++) begin
			taf <= {4{m[1]}};
			for (int p = 0; p < 4; p++) wr16(ra(p, CCAS_OFS_TX_CTRL), 16'(m[0]));
			repeat (3) @(posedge clk);
			flow((m == 0) ? 4'h0 : 4'hF, 4'hF);
		end
		$display("test data path done");
		for (int p = 0; p < 4; p++) begin
			wr16(ra(p, CCAS_OFS_RX_IE), 16'h0000);
			wr16(ra(p, CCAS_OFS_RX_LATCH), 16'h0101);
		end
		ichk(1'b0);
		ua <= 4'hA;
		repeat (3) @(posedge clk);
		for (int p = 0; p < 4; p++) begin
			rchk(ra(p, CCAS_OFS_RX_LIVE), {7'h00, ua[p], 7'h00, 1'b1});
			rchk(ra(p, CCAS_OFS_RX_LATCH), {7'h00, ua[p], 8'h00});
		end
		$display("test status done");
		ichk(1'b0);
		wr16(ra(1, CCAS_OFS_RX_IE), 16'h0100);
		ichk(1'b1);
		wr16(ra(1, CCAS_OFS_RX_LATCH), 16'h0100);
		ichk(1'b0);
		rchk(ra(1, CCAS_OFS_RX_LATCH), 16'h0000);
		ua <= 4'h0;
		ichk(1'b1);
		wr16(ra(1, CCAS_OFS_RX_IE), 16'h0000);
		ichk(1'b0);
		for (int p = 0; p < 4; p++) wr16(ra(p, CCAS_OFS_RX_LATCH), 16'h0101);
		wr16(ra(2, CCAS_OFS_RX_IE), 16'h0001);
		slow <= 1'b1;
		lreq <= 4'hB;
		repeat (10) @(posedge clk);
		ichk(1'b1);
		rchk(ra(2, CCAS_OFS_RX_LIVE), 16'h0000);
		rchk(ra(2, CCAS_OFS_RX_LATCH), 16'h0001);
		rchk(ra(3, CCAS_OFS_RX_LATCH), 16'h0000);
		$display("test interrupt done");
		results();
	end
endmodule : tb

`default_nettype wire
